/* lue_pkg.sv */
package lue_pkg;

	// ========================================================================
	// Clock and default bit timing
	// ========================================================================
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned DEF_BAUD      = 115_200;
	localparam int unsigned DIV_W         = 16;
	localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / DEF_BAUD);

	// ========================================================================
	// Register map (byte addresses on the plain register port)
	// ========================================================================
	localparam int unsigned ADDR_W     = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_BAUD  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_MASK  = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_RXD   = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_TXD   = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h18;

	// Control register fields.
	localparam int unsigned CTRL_W        = 3;
	localparam int unsigned CTL_EN        = 0;
	localparam int unsigned CTL_UART_MODE = 1;
	localparam int unsigned CTL_PLAIN     = 2;
	localparam int unsigned CTL_SYNC_ARM  = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

	// Receive and transmit error status register fields; the mask register has the same layout.
	localparam int unsigned ST_W       = 6;
	localparam int unsigned ST_BITERR  = 0;
	localparam int unsigned ST_FRAME   = 1;
	localparam int unsigned ST_OVERRUN = 2;
	localparam int unsigned ST_SYNC    = 3;
	localparam int unsigned ST_BREAK   = 5;
	localparam logic [ST_W-1:0] ST_RESET = 6'h00;

	// ========================================================================
	// Character and sync-field timing
	// ========================================================================
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	localparam logic [3:0] BREAK_BITS    = 4'ha;
	localparam logic [2:0] SYNC_EDGES    = 3'h5;
	localparam int unsigned SPAN_W       = 20;
	localparam int unsigned SPAN_SHIFT   = 3;
	localparam int unsigned TOL_SHIFT    = 2;
	localparam int unsigned TIMEOUT_SHIFT = 4;

	// ========================================================================
	// Types
	// ========================================================================
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} lue_bus_req_t;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BREAK
	} lue_rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE, TX_START, TX_DATA, TX_STOP
	} lue_tx_state_t;

endpackage : lue_pkg

/* lue_baud_tick.sv */
`timescale 1ns/1ps

// Bit-period divider: gives one pulse in the middle and one at the end of
// every bit period, restarted on a frame's first edge.
module lue_baud_tick (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     resetn,
	// Control
	input  wire logic                     restart,
	input  wire logic [lue_pkg::DIV_W-1:0] div,
	// Enables
	output logic                          mid,
	output logic                          full
);
	import lue_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
	} lue_tick_t;

	lue_tick_t st;
	lue_tick_t next_st;

	// Decoded from the counter; the top registers everything it exports.
	assign mid  = (st.cnt == (div >> 1));
	assign full = (st.cnt == DIV_W'(div - 1'b1));

	// Count up and wrap at the end of each bit period.
	always_comb begin
		next_st = st;
		if (restart || full) begin
			next_st.cnt = '0;
		end else begin
			next_st.cnt = DIV_W'(st.cnt + 1'b1);
		end
	end

	// State register.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule : lue_baud_tick

/* lue_sync_meter.sv */
`timescale 1ns/1ps

// Measures a 0x55 sync field: five falling edges span eight bit periods.
module lue_sync_meter (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     resetn,
	// Control and line
	input  wire logic                     arm,
	input  wire logic                     line,
	input  wire logic [lue_pkg::DIV_W-1:0] div,
	// Result
	output logic                          done,
	output logic                          ok,
	output logic [lue_pkg::DIV_W-1:0]     meas
);
	import lue_pkg::*;

	typedef struct packed {
		logic              active;
		logic              counting;
		logic [2:0]        edges;
		logic [SPAN_W-1:0] span;
		logic              prev;
		logic              done;
		logic              ok;
		logic [DIV_W-1:0]  meas;
	} lue_sync_t;

	lue_sync_t st;
	lue_sync_t next_st;
	logic [DIV_W-1:0] per_bit;
	logic [DIV_W-1:0] diff;
	logic             falling;
	logic             timeout;

	assign done = st.done;
	assign ok   = st.ok;
	assign meas = st.meas;

	// Per-bit figure and its distance from the configured divisor.
	always_comb begin
		per_bit = DIV_W'(st.span >> SPAN_SHIFT);
		diff    = (per_bit > div) ? DIV_W'(per_bit - div)
		                          : DIV_W'(div - per_bit);
		falling = st.prev && !line;
		timeout = st.span > (SPAN_W'(div) << TIMEOUT_SHIFT);
	end

	// Edge counting; a stuck line ends the measurement as a failure.
	always_comb begin
		next_st      = st;
		next_st.prev = line;
		next_st.done = 1'b0;
		if (arm) begin
			next_st.active   = 1'b1;
			next_st.counting = 1'b0;
			next_st.edges    = '0;
		end else if (st.active) begin
			if (st.counting) begin
				next_st.span = SPAN_W'(st.span + 1'b1);
			end
			if (falling && !st.counting) begin
				next_st.counting = 1'b1;
				next_st.span     = SPAN_W'(1'b1); // R8
				next_st.edges    = 3'h1;
			end else if (falling) begin
				next_st.edges = 3'(st.edges + 1'b1);
				if (next_st.edges == SYNC_EDGES) begin
					next_st.active = 1'b0;
					next_st.done   = 1'b1;
					next_st.meas   = per_bit;
					next_st.ok     = diff <= (div >> TOL_SHIFT); // R9
				end
			end else if (st.counting && timeout) begin
				next_st.active = 1'b0;
				next_st.done   = 1'b1;
				next_st.ok     = 1'b0; // R9
			end
		end
	end

	// State register; the line is idle high before the first sample.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st      <= '0;
			st.prev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule : lue_sync_meter

/* lue_err_detect.sv */
`timescale 1ns/1ps

// What this block does
// (R1) Transmit read-back mismatch sets bit-error flag.
// (R2) Bit error aborts transmit by next byte.
// (R3) Low ten bits after bad stop: break.
// (R4) LIN-pin break only in UART-compatible mode.
// (R5) Missing stop bit sets framing-error flag.
// (R6) UART-compatible mode checks first stop bit only.
// (R7) Framing interrupt only with receive-error enable.
// (R8) Measure sync field, adjust baud divisor.
// (R9) Sync outside tolerance sets sync-error flag.
// (R10) Overwriting unread character sets overrun flag.
// (R11) Overrun interrupt only when its enable set.
// (R12) Plain port: new data replaces, flags loss.
// (R13) Plain port: format mismatch flagged, interrupt enabled.
// (R14) Flags stay set until software clears.
module lue_err_detect (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	// Register port
	input  wire lue_pkg::lue_bus_req_t bus,
	output logic [31:0]                rdata,
	// Serial lines
	input  wire logic                  serial_receive_pin,
	input  wire logic                  lin_receive_pin,
	output logic                       tx_pin,
	// Interrupt
	output logic                       irq
);
	import lue_pkg::*;

	// ========================================================================
	// State
	// ========================================================================
	typedef struct packed {
		lue_rx_state_t     rx;
		lue_tx_state_t     tx;
		logic [7:0]        rx_shift;
		logic [2:0]        rx_cnt;
		logic [3:0]        brk_cnt;
		logic              brk_done;
		logic [7:0]        rx_buf;
		logic              rx_full;
		logic [7:0]        tx_shift;
		logic [2:0]        tx_cnt;
		logic              tx_line;
		logic [CTRL_W-1:0] ctrl;
		logic [DIV_W-1:0]  div;
		logic [ST_W-1:0]   status;
		logic [ST_W-1:0]   mask;
		logic [31:0]       rdata;
		logic              irq;
	} lue_core_t;

	lue_core_t st;
	lue_core_t next_st;

	logic             line;
	logic             brk_allowed;
	logic             rx_restart;
	logic             rx_mid;
	logic             tx_restart;
	logic             tx_mid;
	logic             tx_full;
	logic             sync_arm;
	logic             sync_done;
	logic             sync_ok;
	logic [DIV_W-1:0] sync_meas;
	logic [ST_W-1:0]  set_ev;
	logic [ST_W-1:0]  clr_ev;
	logic             deliver;

	assign rdata  = st.rdata;
	assign tx_pin = st.tx_line;
	assign irq    = st.irq;

	// True when the port addresses the given register.
	function automatic logic hit(input logic [ADDR_W-1:0] a,
	                             input logic [ADDR_W-1:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	// ========================================================================
	// Line selection and helpers
	// ========================================================================
	// The plain port always watches for breaks; the LIN pin only does so
	// while the LIN block runs in its UART-compatible mode.
	always_comb begin
		line        = st.ctrl[CTL_PLAIN] ? serial_receive_pin
		                                 : lin_receive_pin;
		brk_allowed = st.ctrl[CTL_PLAIN] || st.ctrl[CTL_UART_MODE]; // R4
		rx_restart  = (st.rx == RX_IDLE) && !line;
		tx_restart  = (st.tx == TX_IDLE) && bus.wr &&
		              hit(bus.addr, ADDR_TXD) && st.ctrl[CTL_EN];
		sync_arm    = bus.wr && hit(bus.addr, ADDR_CTRL) &&
		              bus.wdata[CTL_SYNC_ARM] && !bus.wdata[CTL_PLAIN];
	end

	lue_baud_tick u_rx_tick (
		.mclk    (mclk),
		.resetn  (resetn),
		.restart (rx_restart),
		.div     (st.div),
		.mid     (rx_mid),
		.full    ()
	);

	lue_baud_tick u_tx_tick (
		.mclk    (mclk),
		.resetn  (resetn),
		.restart (tx_restart),
		.div     (st.div),
		.mid     (tx_mid),
		.full    (tx_full)
	);

	lue_sync_meter u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.arm    (sync_arm),
		.line   (line),
		.div    (st.div),
		.done   (sync_done),
		.ok     (sync_ok),
		.meas   (sync_meas)
	);

	// ========================================================================
	// Next-state logic
	// ========================================================================
	always_comb begin
		next_st = st;
		set_ev  = '0;
		clr_ev  = '0;
		deliver = 1'b0;

		// Receiver: every decision after the start edge is taken at mid-bit.
		unique case (st.rx)
			RX_IDLE: begin
				if (st.ctrl[CTL_EN] && !line) begin
					next_st.rx = RX_START;
				end
			end
			RX_START: begin
				if (rx_mid) begin
					next_st.rx     = line ? RX_IDLE : RX_DATA;
					next_st.rx_cnt = '0;
				end
			end
			RX_DATA: begin
				if (rx_mid) begin
					next_st.rx_shift = {line, st.rx_shift[7:1]};
					next_st.rx_cnt   = 3'(st.rx_cnt + 1'b1);
					if (st.rx_cnt == LAST_DATA_BIT) begin
						next_st.rx = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				// Only one stop bit is sampled; a second configured stop
				// bit is then just idle line ahead of the next start.
				if (rx_mid) begin // R6
					if (line) begin
						deliver    = 1'b1;
						next_st.rx = RX_IDLE;
					end else begin
						set_ev[ST_FRAME] = 1'b1; // R5 R13
						next_st.brk_cnt  = 4'h0;
						next_st.brk_done = 1'b0;
						next_st.rx = brk_allowed ? RX_BREAK : RX_IDLE; // R4
					end
				end
			end
			RX_BREAK: begin
				// Count further low bit periods after the bad stop bit.
				if (rx_mid) begin
					if (line) begin
						next_st.rx = RX_IDLE;
					end else if (!st.brk_done) begin
						next_st.brk_cnt = 4'(st.brk_cnt + 1'b1);
						if (next_st.brk_cnt == BREAK_BITS) begin
							set_ev[ST_BREAK] = 1'b1; // R3
							next_st.brk_done = 1'b1;
						end
					end
				end
			end
		endcase

		// Receive buffer: a new character always replaces the old one.
		if (deliver) begin
			next_st.rx_buf  = st.rx_shift;
			next_st.rx_full = 1'b1;
			if (st.rx_full) begin
				set_ev[ST_OVERRUN] = 1'b1; // R10 R12
			end
		end else if (bus.rd && hit(bus.addr, ADDR_RXD)) begin
			next_st.rx_full = 1'b0;
		end

		// Transmitter with bit monitor; the line is compared at mid-bit.
		unique case (st.tx)
			TX_IDLE: begin
				if (tx_restart) begin
					next_st.tx       = TX_START;
					next_st.tx_shift = bus.wdata[7:0];
					next_st.tx_line  = 1'b0;
				end
			end
			TX_START, TX_DATA, TX_STOP: begin
				if (tx_mid && (line != st.tx_line)) begin
					// Aborting at once is earlier than the byte boundary
					// and frees the line for the winner of the collision.
					set_ev[ST_BITERR] = 1'b1; // R1
					next_st.tx        = TX_IDLE; // R2
					next_st.tx_line   = 1'b1; // R2
				end else if (tx_full) begin
					if (st.tx == TX_START) begin
						next_st.tx      = TX_DATA;
						next_st.tx_cnt  = '0;
						next_st.tx_line = st.tx_shift[0];
					end else if (st.tx == TX_DATA) begin
						next_st.tx_shift = {1'b1, st.tx_shift[7:1]};
						next_st.tx_cnt   = 3'(st.tx_cnt + 1'b1);
						if (st.tx_cnt == LAST_DATA_BIT) begin
							next_st.tx      = TX_STOP;
							next_st.tx_line = 1'b1;
						end else begin
							next_st.tx_line = st.tx_shift[1];
						end
					end else begin
						next_st.tx = TX_IDLE;
					end
				end
			end
		endcase

		// Sync field: adopt the measured divisor or flag the field.
		if (sync_done) begin
			if (sync_ok) begin
				next_st.div = sync_meas; // R8
			end else begin
				set_ev[ST_SYNC] = 1'b1; // R9
			end
		end

		// Register writes.
		if (bus.wr) begin
			if (hit(bus.addr, ADDR_CTRL)) begin
				next_st.ctrl = bus.wdata[CTRL_W-1:0];
			end
			if (hit(bus.addr, ADDR_BAUD) && !(sync_done && sync_ok)) begin
				next_st.div = bus.wdata[DIV_W-1:0];
			end
			if (hit(bus.addr, ADDR_STAT)) begin
				clr_ev = bus.wdata[ST_W-1:0];
			end
			if (hit(bus.addr, ADDR_MASK)) begin
				next_st.mask = bus.wdata[ST_W-1:0];
			end
		end

		// Sticky flags: a new event beats a clear in the same cycle.
		next_st.status = (st.status & ~clr_ev) | set_ev; // R14

		// Each source reaches the pin only through its own enable.
		next_st.irq = |(next_st.status & st.mask); // R7 R11 R12 R13

		// Read data stands only in the cycle after the read strobe.
		next_st.rdata = '0;
		if (bus.rd) begin
			if (hit(bus.addr, ADDR_CTRL)) begin
				next_st.rdata = 32'(st.ctrl);
			end else if (hit(bus.addr, ADDR_BAUD)) begin
				next_st.rdata = 32'(st.div);
			end else if (hit(bus.addr, ADDR_STAT)) begin
				next_st.rdata = 32'(st.status);
			end else if (hit(bus.addr, ADDR_MASK)) begin
				next_st.rdata = 32'(st.mask);
			end else if (hit(bus.addr, ADDR_RXD)) begin
				next_st.rdata = 32'(st.rx_buf);
			end else if (hit(bus.addr, ADDR_STATE)) begin
				next_st.rdata = 32'({st.rx_full, st.tx != TX_IDLE,
				                     st.rx != RX_IDLE});
			end
		end
	end

	// ========================================================================
	// State register
	// ========================================================================
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st         <= '0;
			st.rx      <= RX_IDLE;
			st.tx      <= TX_IDLE;
			st.tx_line <= 1'b1;
			st.ctrl    <= CTRL_RESET;
			st.div     <= DIV_RESET;
			st.status  <= ST_RESET;
			st.mask    <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

endmodule : lue_err_detect

/* lue_err_checker.sv */
`timescale 1ns/1ps

// ====
// Port-level checks of the error detector
// ====
module lue_err_checker (
	// Clock and reset
	input wire logic                  mclk,
	input wire logic                  resetn,
	// Register port
	input wire lue_pkg::lue_bus_req_t bus,
	input wire logic [31:0]           rdata,
	// Serial lines and interrupt
	input wire logic                  serial_receive_pin,
	input wire logic                  lin_receive_pin,
	input wire logic                  tx_pin,
	input wire logic                  irq
);
	import lue_pkg::*;

	logic [CTRL_W-1:0] ctrl_q;
	logic [ST_W-1:0]   mask_q;
	logic              en_seen;

	// Shadows of the software-owned registers; hardware never writes the
	// mask or the control bits, so a copy taken off the bus stays exact.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_q  <= CTRL_RESET;
			mask_q  <= ST_RESET;
			en_seen <= 1'b0;
		end else if (bus.wr && bus.addr == ADDR_CTRL) begin
			ctrl_q  <= bus.wdata[CTRL_W-1:0];
			en_seen <= en_seen | bus.wdata[CTL_EN];
		end else if (bus.wr && bus.addr == ADDR_MASK) begin
			mask_q <= bus.wdata[ST_W-1:0];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Read answers.
	a_rdata_idle: assert property (!bus.rd |=> rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h1c
		|=> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_readback: assert property (bus.rd && bus.addr == ADDR_CTRL
		|=> rdata == {29'h0, ctrl_q})
		else $error("control readback differs from last write");
	a_baud_readback: assert property (bus.wr && bus.addr == ADDR_BAUD
		##2 bus.rd && bus.addr == ADDR_BAUD
		|=> rdata[15:0] == $past(bus.wdata[15:0], 3))
		else $error("bit period readback differs from write");
	a_stat_spare: assert property (bus.rd && bus.addr == ADDR_STAT
		|=> rdata[31:ST_W] == 26'h0 && rdata[4] == 1'b0)
		else $error("spare status bits not zero");

	// The interrupt is the status masked by the mask of one cycle before.
	a_irq_masked: assert property (
		mask_q == 6'h00 && $past(mask_q) == 6'h00 |-> !irq)
		else $error("interrupt with every source masked");
	a_irq_follows: assert property (
		bus.rd && bus.addr == ADDR_STAT && $stable(mask_q)
		|=> $past(irq) == |(rdata[ST_W-1:0] & $past(mask_q)))
		else $error("interrupt level disagrees with masked status");

	// Nothing leaves the transmitter before it was ever enabled.
	a_tx_quiet: assert property (!en_seen |-> tx_pin)
		else $error("transmit line active while never enabled");
endmodule : lue_err_checker

bind lue_err_detect lue_err_checker chk (
	.mclk              (mclk),
	.resetn            (resetn),
	.bus               (bus),
	.rdata             (rdata),
	.serial_receive_pin(serial_receive_pin),
	.lin_receive_pin   (lin_receive_pin),
	.tx_pin            (tx_pin),
	.irq               (irq)
);

/* lue_node.sv */
`timescale 1ns/1ps

// ====
// Far-side serial node
// ====
// Open-drain drive: 0 pulls the line low, 1 lets the pull-up win.
module lue_node (
	// Clock
	input wire logic mclk,
	// Line drive
	output logic     nd
);
	initial nd = 1'b1;

	// One character, LSB first, at any bit period; a low stop plus a low
	// tail of whole bits builds a break.
	task automatic send(input logic [7:0] b, input logic stp,
		input int per, input int tail);
		logic [9:0] bits;
		bits = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			nd <= bits[i];
			repeat (per) @(posedge mclk);
		end
		if (tail > 0) begin
			nd <= 1'b0;
			repeat (tail * per) @(posedge mclk);
		end
		nd <= 1'b1;
		repeat (2 * per) @(posedge mclk);
	endtask : send

	// Holds the line low for a while, to collide with a transmitter.
	task automatic pull(input int n);
		nd <= 1'b0;
		repeat (n) @(posedge mclk);
		nd <= 1'b1;
	endtask : pull
endmodule : lue_node

/* tb.sv */
`timescale 1ns/1ps

module tb;
	import lue_pkg::*;

	localparam int P  = 16;
	localparam int PS = 18;
	localparam int PB = 30;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	localparam logic [31:0] BE  = 32'h1 << ST_BITERR;
	localparam logic [31:0] FR  = 32'h1 << ST_FRAME;
	localparam logic [31:0] OV  = 32'h1 << ST_OVERRUN;
	localparam logic [31:0] SY  = 32'h1 << ST_SYNC;
	localparam logic [31:0] BK  = 32'h1 << ST_BREAK;

	// ====
	// Wiring
	// ====
	logic         mclk;
	logic         resetn;
	lue_bus_req_t bus;
	logic [31:0]  rdata;
	logic         tx_pin;
	logic         irq;
	logic         nd;
	logic         use_plain;
	logic         rd_q;
	int           n_errors;
	int           n_checks;
	int           seed;
	logic [7:0]   b1;
	logic [7:0]   b2;
	logic [63:0]  note_q[$];
	logic [63:0]  note;
	wire logic    lin_line;
	wire logic    ser_line;

	// Both pins share the bus with our own transmitter; the unused one carries
	// only that transmitter and not the node, so a wrong pin choice shows up as silence.
	assign lin_line = tx_pin & (use_plain | nd);
	assign ser_line = tx_pin & (~use_plain | nd);

	lue_err_detect dut (.mclk(mclk), .resetn(resetn), .bus(bus),
		.rdata(rdata), .serial_receive_pin(ser_line),
		.lin_receive_pin(lin_line), .tx_pin(tx_pin), .irq(irq));
	lue_node node (.mclk(mclk), .nd(nd));

	// Clock.
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ====
	// Tasks
	// ====
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input logic [31:0] msk);
		n_checks++;
		if ((seen & msk) !== (exp & msk)) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge mclk);
		bus.wr    <= 1'b0;
	endtask : wr

	// The expected answer is noted now and judged by the monitor.
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge mclk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		note_q.push_back({e, m});
		@(posedge mclk);
		bus.rd   <= 1'b0;
	endtask : rd

	task automatic irq_is(input logic e);
		repeat (3) @(posedge mclk);
		#1;
		check({31'h0, irq}, {31'h0, e}, 32'h1);
	endtask : irq_is

	// Stray frames after a long low need a full character to die out.
	task automatic flush();
		repeat (12 * P) @(posedge mclk);
		wr(ADDR_STAT, 32'h3f);
		rd(ADDR_RXD, 32'h0, 32'h0);
	endtask : flush

	// Read data stand only in the cycle after the strobe.
	always @(posedge mclk) begin
		if (rd_q) begin
			note = note_q.pop_front();
			check(rdata, note[63:32], note[31:0]);
		end
		rd_q <= bus.rd;
	end

	// Watchdog.
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		wrap_up();
	end

	// ====
	// Scenarios
	// ====
	initial begin
		bus = '0;
		resetn = 1'b0;
		use_plain = 1'b0;
		rd_q = 1'b0;
		n_errors = 0;
		n_checks = 0;
		seed = 85454;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		rd(ADDR_CTRL, 32'h0, ALL);
		rd(ADDR_BAUD, 32'(DIV_RESET), ALL);
		rd(ADDR_STAT, 32'h0, ALL);
		rd(ADDR_MASK, 32'h0, ALL);
		wr(8'h1c, ALL);
		rd(8'h1c, 32'h0, ALL);
		wr(ADDR_BAUD, 32'(P));
		rd(ADDR_BAUD, 32'(P), ALL);
		wr(ADDR_CTRL, 32'h1);
		// Clean character, then two unread ones in a row.
		b1 = 8'($random(seed));
		b2 = 8'($random(seed));
		node.send(b1, 1'b1, P, 0);
		rd(ADDR_STAT, 32'h0, ALL);
		rd(ADDR_RXD, {24'h0, b1}, ALL);
		node.send(b1, 1'b1, P, 0);
		node.send(b2, 1'b1, P, 0);
		rd(ADDR_STAT, OV, ALL);
		irq_is(1'b0);
		wr(ADDR_MASK, OV);
		irq_is(1'b1);
		rd(ADDR_RXD, {24'h0, b2}, ALL);
		rd(ADDR_STAT, OV, ALL);
		flush();
		irq_is(1'b0);
		// Missing stop bit, first with break checking off, then on.
		wr(ADDR_MASK, 32'h0);
		node.send(b1, 1'b0, P, 11);
		rd(ADDR_STAT, FR, FR | BK);
		irq_is(1'b0);
		wr(ADDR_MASK, FR);
		irq_is(1'b1);
		flush();
		wr(ADDR_CTRL, 32'h3);
		node.send(b2, 1'b0, P, 11);
		rd(ADDR_STAT, FR | BK, FR | BK);
		flush();
		// Plain port on its own pin.
		use_plain <= 1'b1;
		wr(ADDR_CTRL, 32'h5);
		node.send(b1, 1'b1, P, 0);
		node.send(b2, 1'b1, P, 0);
		rd(ADDR_STAT, OV, ALL);
		rd(ADDR_RXD, {24'h0, b2}, ALL);
		flush();
		node.send(b1, 1'b0, P, 11);
		rd(ADDR_STAT, FR | BK, ALL);
		irq_is(1'b1);
		flush();
		use_plain <= 1'b0;
		wr(ADDR_CTRL, 32'h1);
		// Transmit read back cleanly, then a collision in data bit 0.
		b1 = 8'($random(seed));
		wr(ADDR_TXD, {24'h0, b1});
		rd(ADDR_STATE, 32'h3, ALL);
		repeat (12 * P) @(posedge mclk);
		rd(ADDR_STAT, 32'h0, BE);
		rd(ADDR_RXD, {24'h0, b1}, ALL);
		wr(ADDR_TXD, 32'h1);
		repeat (P + 2) @(posedge mclk);
		node.pull(12);
		repeat (30) @(posedge mclk);
		#1;
		check({31'h0, tx_pin}, 32'h1, 32'h1);
		rd(ADDR_STAT, BE, BE);
		flush();
		// Sync field near the set rate, then one far off it.
		wr(ADDR_CTRL, 32'h9);
		node.send(8'h55, 1'b1, PS, 0);
		rd(ADDR_BAUD, 32'(PS), ALL);
		flush();
		wr(ADDR_CTRL, 32'h9);
		node.send(8'h55, 1'b1, PB, 0);
		rd(ADDR_STAT, SY, SY);
		rd(ADDR_BAUD, 32'(PS), ALL);
		repeat (4) @(posedge mclk);
		wrap_up();
	end
endmodule : tb
